// ---- hw/scr_defs.svh ----
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// Opcode encodings
`define SCR_OP_PUSH 16'h0005
`define SCR_OP_SOFT_RESET 16'h00ff
`define SCR_CALL_MASK 16'hf800
`define SCR_CALL_MATCH 16'hd800

// Program counter values
`define SCR_PROG_RESET 21'h000000
`define SCR_PROG_STEP 21'h000002

// Offset field
`define SCR_OFS_MSB 10
`define SCR_OFS_W 11

// Quarters per instruction cycle
`define SCR_QUARTERS 4

`endif

// ---- hw/scr_pkg.sv ----
package scr_pkg;

    typedef enum logic [1:0] {
        SCR_Q1,
        SCR_Q2,
        SCR_Q3,
        SCR_Q4
    } scr_quarter_t;

    typedef enum logic [2:0] {
        SCR_OP_NONE,
        SCR_OP_OTHER,
        SCR_OP_PUSH_RET,
        SCR_OP_CALL,
        SCR_OP_SWRST
    } scr_op_t;

    typedef enum logic {
        SCR_ST_RUN,
        SCR_ST_IDLE2
    } scr_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } scr_instr_t;

    typedef struct packed {
        logic push;
        logic [20:0] data;
    } scr_push_t;

endpackage

// ---- hw/scr_qgen.sv ----
`timescale 1ns/10ps
`default_nettype none

module scr_qgen (
    input wire logic ref_clk,
    input wire logic nrst,
    output scr_pkg::scr_quarter_t quarter_q
);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            quarter_q <= scr_pkg::SCR_Q1;
        end else begin
            unique case (quarter_q)
                scr_pkg::SCR_Q1: quarter_q <= scr_pkg::SCR_Q2;
                scr_pkg::SCR_Q2: quarter_q <= scr_pkg::SCR_Q3;
                scr_pkg::SCR_Q3: quarter_q <= scr_pkg::SCR_Q4;
                scr_pkg::SCR_Q4: quarter_q <= scr_pkg::SCR_Q1;
            endcase
        end
    end

endmodule // scr_qgen

`default_nettype wire

// ---- hw/scr_exec.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"

// Operation
// - Opcode 0005h pushes program counter plus two
// - Push moves former top one level down
// - Push: one cycle, push in Q2
// - Pattern 11011 plus signed 11-bit offset
// - Call pushes return, jumps to return plus 2n
// - Call takes two cycles, second idle
// - Call: Q2 push, Q3 sum, Q4 write
// - Opcode 00FFh restores master clear state
// - Software reset: one word, one cycle
module scr_exec #(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire scr_pkg::scr_instr_t instr,
    output logic instr_taken_q,
    output logic [20:0] program_counter_q,
    output logic [20:0] top_of_return_stack,
    output logic [20:0] stack_below_top,
    output scr_pkg::scr_push_t push_q,
    output logic master_clear_req_q,
    output scr_pkg::scr_quarter_t quarter_q,
    output logic idle_cycle_q
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic scr_pkg::scr_op_t scr_decode(input logic [15:0] w);
        if (w == `SCR_OP_PUSH) begin
            return scr_pkg::SCR_OP_PUSH_RET;
        end else if ((w & `SCR_CALL_MASK) == `SCR_CALL_MATCH) begin
            return scr_pkg::SCR_OP_CALL;
        end else if (w == `SCR_OP_SOFT_RESET) begin
            return scr_pkg::SCR_OP_SWRST;
        end
        return scr_pkg::SCR_OP_OTHER;
    endfunction

    scr_pkg::scr_op_t op_q;
    scr_pkg::scr_state_t state_q;
    logic [`SCR_OFS_W-1:0] offset_q;
    logic [20:0] target_q;
    logic [20:0] stack_q [DEPTH];
    logic [20:0] ret_addr;
    logic [20:0] offset_x2;
    logic take;

    scr_qgen u_scr_qgen (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .quarter_q(quarter_q)
    );

    assign ret_addr = program_counter_q + `SCR_PROG_STEP;
    // Sign-extended word offset doubled to a byte offset
    assign offset_x2 = {{(21-`SCR_OFS_W-1){offset_q[`SCR_OFS_MSB]}}, offset_q, 1'b0};
    assign take = (quarter_q == scr_pkg::SCR_Q1) && (state_q == scr_pkg::SCR_ST_RUN)
                  && instr.valid;
    assign top_of_return_stack = stack_q[0];
    assign stack_below_top = stack_q[1];

    // ------------------------------------------------------------
    // Instruction latch
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            op_q <= scr_pkg::SCR_OP_NONE;
            offset_q <= '0;
            instr_taken_q <= 1'b0;
        end else begin
            instr_taken_q <= take;
            if (take) begin
                op_q <= scr_decode(instr.word);
                offset_q <= instr.word[`SCR_OFS_MSB:0];
            end else if (quarter_q == scr_pkg::SCR_Q4) begin
                op_q <= scr_pkg::SCR_OP_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Cycle state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= scr_pkg::SCR_ST_RUN;
            idle_cycle_q <= 1'b0;
        end else if (quarter_q == scr_pkg::SCR_Q4) begin
            unique case (state_q)
                scr_pkg::SCR_ST_RUN: begin
                    if (op_q == scr_pkg::SCR_OP_CALL) begin
                        state_q <= scr_pkg::SCR_ST_IDLE2;
                        idle_cycle_q <= 1'b1;
                    end
                end
                scr_pkg::SCR_ST_IDLE2: begin
                    state_q <= scr_pkg::SCR_ST_RUN;
                    idle_cycle_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    logic do_push;
    logic do_swrst;
    assign do_push = (quarter_q == scr_pkg::SCR_Q2) &&
                     ((op_q == scr_pkg::SCR_OP_PUSH_RET) || (op_q == scr_pkg::SCR_OP_CALL));
    assign do_swrst = (quarter_q == scr_pkg::SCR_Q2) && (op_q == scr_pkg::SCR_OP_SWRST);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stack_q[0] <= `SCR_PROG_RESET;
        end else if (do_swrst) begin
            stack_q[0] <= `SCR_PROG_RESET;
        end else if (do_push) begin
            stack_q[0] <= ret_addr;
        end
    end

    for (genvar i = 1; i < DEPTH; i++) begin : g_stack
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                stack_q[i] <= `SCR_PROG_RESET;
            end else if (do_swrst) begin
                stack_q[i] <= `SCR_PROG_RESET;
            end else if (do_push) begin
                stack_q[i] <= stack_q[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            push_q <= '0;
        end else begin
            push_q.push <= do_push;
            push_q.data <= do_swrst ? `SCR_PROG_RESET : (do_push ? ret_addr : push_q.data);
        end
    end

    // ------------------------------------------------------------
    // Program counter and software reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            target_q <= `SCR_PROG_RESET;
        end else if (do_swrst) begin
            target_q <= `SCR_PROG_RESET;
        end else if ((quarter_q == scr_pkg::SCR_Q3) && (op_q == scr_pkg::SCR_OP_CALL)) begin
            target_q <= ret_addr + offset_x2;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            program_counter_q <= `SCR_PROG_RESET;
        end else if (do_swrst) begin
            program_counter_q <= `SCR_PROG_RESET;
        end else if (quarter_q == scr_pkg::SCR_Q4) begin
            unique case (op_q)
                scr_pkg::SCR_OP_CALL: program_counter_q <= target_q;
                scr_pkg::SCR_OP_PUSH_RET, scr_pkg::SCR_OP_OTHER: begin
                    program_counter_q <= ret_addr;
                end
                scr_pkg::SCR_OP_NONE, scr_pkg::SCR_OP_SWRST: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            master_clear_req_q <= 1'b0;
        end else begin
            master_clear_req_q <= do_swrst;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_PUSH_Q2: assert property (@(posedge ref_clk) disable iff (!nrst)
        push_q.push |-> $past(quarter_q) == scr_pkg::SCR_Q2)
        else $error("push outside second quarter");

    AST_PUSH_DATA: assert property (@(posedge ref_clk) disable iff (!nrst)
        do_push |=> top_of_return_stack == $past(program_counter_q) + `SCR_PROG_STEP)
        else $error("pushed value is not counter plus two");

    AST_PUSH_DOWN: assert property (@(posedge ref_clk) disable iff (!nrst)
        do_push |=> stack_below_top == $past(top_of_return_stack))
        else $error("former top not moved down");

    AST_PUSH_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && scr_decode(instr.word) == scr_pkg::SCR_OP_PUSH_RET
        |-> ##4 (quarter_q == scr_pkg::SCR_Q1 && state_q == scr_pkg::SCR_ST_RUN
                 && program_counter_q == $past(program_counter_q, 4) + `SCR_PROG_STEP))
        else $error("push did not finish in one cycle");

    AST_CALL_TARGET: assert property (@(posedge ref_clk) disable iff (!nrst)
        (quarter_q == scr_pkg::SCR_Q4 && op_q == scr_pkg::SCR_OP_CALL)
        |=> program_counter_q == $past(program_counter_q) + `SCR_PROG_STEP
            + 21'($signed({$past(offset_q), 1'b0})))
        else $error("call target not written in fourth quarter");

    AST_CALL_IDLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (quarter_q == scr_pkg::SCR_Q4 && op_q == scr_pkg::SCR_OP_CALL)
        |=> (idle_cycle_q && !push_q.push && !take)[*4] ##1 !idle_cycle_q)
        else $error("second call cycle not idle");

    AST_CALL_SUM: assert property (@(posedge ref_clk) disable iff (!nrst)
        (quarter_q == scr_pkg::SCR_Q3 && op_q == scr_pkg::SCR_OP_CALL)
        |=> target_q == $past(program_counter_q) + `SCR_PROG_STEP
            + 21'($signed({$past(offset_q), 1'b0})))
        else $error("call sum wrong");

    AST_SWRST: assert property (@(posedge ref_clk) disable iff (!nrst)
        do_swrst |=> master_clear_req_q && program_counter_q == `SCR_PROG_RESET
                     && top_of_return_stack == `SCR_PROG_RESET ##1 !master_clear_req_q)
        else $error("software reset incomplete");

    AST_SWRST_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && scr_decode(instr.word) == scr_pkg::SCR_OP_SWRST
        |-> ##4 (quarter_q == scr_pkg::SCR_Q1 && state_q == scr_pkg::SCR_ST_RUN))
        else $error("software reset longer than one cycle");

endmodule // scr_exec

`default_nettype wire

// ---- bench/stack_call_reset_instr_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module stack_call_reset_instr_tb_top;

    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    scr_pkg::scr_instr_t instr = '0;
    logic instr_taken_q, master_clear_req_q, idle_cycle_q;
    logic [20:0] program_counter_q, top_of_return_stack, stack_below_top;
    scr_pkg::scr_push_t push_q;
    scr_pkg::scr_quarter_t quarter_q;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] rng = 32'h16401598;
    logic [20:0] m_prog = '0;
    logic [20:0] m_stk[$];
    logic last_call = 1'b0;

    scr_exec u_scr_exec (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .instr(instr),
        .instr_taken_q(instr_taken_q),
        .program_counter_q(program_counter_q),
        .top_of_return_stack(top_of_return_stack),
        .stack_below_top(stack_below_top),
        .push_q(push_q),
        .master_clear_req_q(master_clear_req_q),
        .quarter_q(quarter_q),
        .idle_cycle_q(idle_cycle_q)
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [20:0] lvl(input int i);
        return (m_stk.size() > i) ? m_stk[i] : 21'h000000;
    endfunction

    task automatic chk_val(input string nm, input logic [20:0] e, input logic [20:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic results;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One instruction, checked against the model quarter by quarter
    // ------------------------------------------------------------
    task automatic exec(input logic [15:0] w, input int gap);
        int n;
        logic [20:0] old_prog;
        logic is_call, is_push, is_rst;
        n = 0;
        is_call = (w & 16'hf800) == 16'hd800;
        is_push = w == 16'h0005;
        is_rst = w == 16'h00ff;
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        instr <= '{valid: 1'b1, word: w};
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n == 1) chk_bit("idle", last_call && gap < 4, idle_cycle_q);
        end while (instr_taken_q !== 1'b1 && n < 12);
        chk_val("take_delay", (last_call && gap < 4) ? 21'h5 : 21'h1, n[20:0]);
        chk_val("quarter", {19'h0, scr_pkg::SCR_Q2}, {19'h0, quarter_q});
        chk_val("program_counter", m_prog, program_counter_q);
        chk_val("top_early", lvl(0), top_of_return_stack);
        old_prog = m_prog;
        if (is_push || is_call) m_stk.push_front(old_prog + 21'h2);
        if (is_rst) m_stk.delete();
        m_prog = is_rst ? 21'h0 : old_prog + 21'h2;
        if (is_call) m_prog = m_prog + {{9{w[10]}}, w[10:0], 1'b0};
        @(posedge ref_clk);
        instr.valid <= 1'b0;
        #1;
        chk_bit("push", is_push || is_call, push_q.push);
        if (is_push || is_call) chk_val("push_data", old_prog + 21'h2, push_q.data);
        chk_val("top", lvl(0), top_of_return_stack);
        chk_val("below", lvl(1), stack_below_top);
        chk_bit("master_clear", is_rst, master_clear_req_q);
        @(posedge ref_clk);
        #1;
        chk_bit("push_end", 1'b0, push_q.push);
        chk_bit("master_clear_end", 1'b0, master_clear_req_q);
        chk_val("counter_hold", is_rst ? 21'h0 : old_prog, program_counter_q);
        last_call = is_call;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        logic [15:0] w;
        repeat (16) @(posedge ref_clk);
        #1;
        chk_val("counter_rst", 21'h0, program_counter_q);
        chk_val("top_rst", 21'h0, top_of_return_stack);
        @(posedge ref_clk);
        nrst <= 1'b1;
        exec(16'h0005, 3);
        exec(16'h0005, 0);
        exec(16'hdc00, 0);
        exec(16'hdbff, 0);
        exec(16'h1234, 0);
        exec(16'h00ff, 4);
        exec(16'hd801, 0);
        for (int i = 0; i < 200; i++) begin
            rng = xs(rng);
            case (rng[1:0])
                2'h0: w = 16'h0005;
                2'h1: w = {5'h1b, rng[26:16]};
                2'h2: w = 16'h00ff;
                default: begin
                    w = rng[31:16];
                    if ((w & 16'hf800) == 16'hd800 || w == 16'h0005 || w == 16'h00ff) w = w ^ 16'h1000;
                end
            endcase
            exec(w, rng[2] ? 4 : 0);
        end
        repeat (2) @(posedge ref_clk);
        #1;
        chk_val("final_counter", m_prog, program_counter_q);
        results();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        results();
    end

endmodule // stack_call_reset_instr_tb_top

`default_nettype wire
